// ### design/mie_move_exec.v
// Execution logic for the core's data-move instructions, with the file registers.
// Assumes the decode stage drives instr and instr_valid on pclk, and software uses APB.
//
// Behaviour
// - File copy to accumulator or back to file
// - File copy sets zero flag from value
// - Indirect load into accumulator, updates zero flag
// - Mode field selects pre/post increment/decrement
// - Offset form: pointer plus signed offset, unchanged
// - Pointers are 16 bits, wrap around
// - Virtual indirect address redirects through pointer
// - Bank literal loads bank select, flags kept
// - Page literal loads pc high latch, flags kept
// - Accumulator literal load, flags kept
// - Store copies accumulator to file, flags kept
// - Pointer steps never touch status flags
`include "mie_defs.vh"

module mie_move_exec #(
    parameter FILE_AW = 7
) (
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Decode port, same clock as the bus
    input  wire        instr_valid,
    input  wire [13:0] instr,
    // Architectural state, all registered
    output reg  [7:0]  acc_q,
    output reg         zero_q,
    output reg  [4:0]  bank_select_register_q,
    output reg  [6:0]  pc_high_latch_q,
    output reg  [15:0] ptr0_q,
    output reg  [15:0] ptr1_q,
    output reg         exec_done_q,
    output reg         bad_op_q
);

    // Array depth follows the file address width
    localparam DEPTH = 1 << FILE_AW;

    // File register storage; kept unreset like any data memory
    reg  [7:0]  file_mem [0:DEPTH-1];
    reg  [6:0]  faddr_q;

    // Pointer pair as a vector so one generate loop updates both
    wire [31:0] ptr_all;
    reg  [31:0] ptr_next;
    assign ptr_all = {ptr1_q, ptr0_q};

    // APB qualifiers; the access phase always completes in its first cycle
    wire        apb_setup;
    wire        apb_acc;
    wire        apb_wr;
    assign apb_setup = psel & ~penable;
    assign apb_acc   = psel & penable & pready;
    assign apb_wr    = apb_acc & pwrite;

    // Instruction source: decode port wins over a software-issued word
    wire        sw_exec;
    wire        go;
    wire [13:0] op;
    assign sw_exec = apb_wr & (paddr == `MIE_OFF_EXEC);
    assign go      = instr_valid | sw_exec;
    assign op      = instr_valid ? instr : pwdata[13:0];

    // Opcode map, fourteen-bit words (d dest, f file, k literal, n pointer, s step mode):
    //   file copy          00 1000 d fffffff
    //   accumulator store  00 0000 1 fffffff
    //   acc literal        11 0000 kkkkkkkk
    //   bank literal       00 0000 001 kkkkk
    //   page literal       11 0001 1 kkkkkkk
    //   indirect load      00 0000 0001 0 n ss
    //   indirect offset    11 1111 0 n kkkkkk (k signed)
    // Anything else raises bad_op_q and changes nothing.
    // Masks and patterns are disjoint, so at most one strobe is high.
    // Opcode decode
    wire is_fcopy;
    wire is_store;
    wire is_alit;
    wire is_blit;
    wire is_plit;
    wire is_iload;
    wire is_iofs;
    wire is_ind;
    assign is_fcopy = (op & `MIE_MSK_FCOPY) == `MIE_PAT_FCOPY;
    assign is_store = (op & `MIE_MSK_STORE) == `MIE_PAT_STORE;
    assign is_alit  = (op & `MIE_MSK_ALIT) == `MIE_PAT_ALIT;
    assign is_blit  = (op & `MIE_MSK_BLIT) == `MIE_PAT_BLIT;
    assign is_plit  = (op & `MIE_MSK_PLIT) == `MIE_PAT_PLIT;
    assign is_iload = (op & `MIE_MSK_ILOAD) == `MIE_PAT_ILOAD;
    assign is_iofs  = (op & `MIE_MSK_IOFS) == `MIE_PAT_IOFS;
    assign is_ind   = is_iload | is_iofs;

    // A word that matches no move pattern leaves the move state alone and raises bad_op_q
    wire known_op;
    assign known_op = is_fcopy | is_store | is_alit | is_blit | is_plit | is_ind;

    // Pointer selection and stepping
    wire        nsel;
    wire [15:0] ptr_cur;
    wire        pre_mode;
    wire        inc_mode;
    wire [15:0] ptr_step;
    wire [15:0] ofs_ext;
    wire [15:0] ind_ea;
    assign nsel     = is_iofs ? op[`MIE_B_NSEL_OFS] : op[`MIE_B_NSEL];
    assign ptr_cur  = nsel ? ptr1_q : ptr0_q;
    assign pre_mode = ~op[1];
    assign inc_mode = ~op[0];
    // 16-bit add drops the carry, which gives the wrap for free
    assign ptr_step = inc_mode ? ptr_cur + `MIE_PTR_ONE
                               : ptr_cur - `MIE_PTR_ONE;
    assign ofs_ext  = {{10{op[5]}}, op[5:0]};
    assign ind_ea   = is_iofs ? ptr_cur + ofs_ext :
                      (pre_mode ? ptr_step : ptr_cur);

    // Direct file address, redirected when it names a virtual indirect register
    wire [6:0]  f_addr;
    wire [15:0] dir_ea;
    assign f_addr = op[6:0];
    assign dir_ea = (f_addr == `MIE_VIRT0) ? ptr0_q :
                    (f_addr == `MIE_VIRT1) ? ptr1_q :
                    {9'h000, f_addr};

    // Only the low bits of an effective address reach the file array
    // Limitation: upper pointer bits are ignored, so far addresses alias onto the array
    wire [15:0]        eff_addr;
    wire [FILE_AW-1:0] mem_idx;
    wire [7:0]         rd_val;
    wire               rd_zero;
    assign eff_addr = is_ind ? ind_ea : dir_ea;
    assign mem_idx  = eff_addr[FILE_AW-1:0];
    assign rd_val   = file_mem[mem_idx];
    assign rd_zero  = (rd_val == 8'h00);

    // Pointer next values, one generate slice per pointer
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_ptr
            always @*
            begin
                ptr_next[gi*16 +: 16] = ptr_all[gi*16 +: 16];
                // A software pointer write loses to a step of the same pointer
                if (go && is_iload && (nsel == gi))
                begin
                    ptr_next[gi*16 +: 16] = ptr_step;
                end
                else if (apb_wr && paddr == ((gi == 0) ? `MIE_OFF_PTR0 : `MIE_OFF_PTR1))
                begin
                    ptr_next[gi*16 +: 16] = pwdata[15:0];
                end
            end
        end
    endgenerate

    // Architectural state; an executing instruction wins over a software write
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q                  <= `MIE_RST_ACC;
            zero_q                 <= 1'b0;
            bank_select_register_q <= `MIE_RST_BANK;
            pc_high_latch_q        <= `MIE_RST_PCHI;
            ptr0_q                 <= `MIE_RST_PTR;
            ptr1_q                 <= `MIE_RST_PTR;
            exec_done_q            <= 1'b0;
            bad_op_q               <= 1'b0;
            faddr_q                <= 7'h00;
        end
        else
        begin
            ptr0_q      <= ptr_next[15:0];
            ptr1_q      <= ptr_next[31:16];
            exec_done_q <= go;
            bad_op_q    <= go & ~known_op;
            if (apb_wr && paddr == `MIE_OFF_FADDR)
            begin
                faddr_q <= pwdata[6:0];
            end
            if (go)
            begin
                if (is_fcopy)
                begin
                    if (!op[`MIE_B_DEST])
                        acc_q <= rd_val;
                    zero_q <= rd_zero;
                end
                else if (is_ind)
                begin
                    acc_q  <= rd_val;
                    zero_q <= rd_zero;
                end
                else if (is_alit)
                begin
                    acc_q <= op[7:0];
                end
                else if (is_blit)
                begin
                    bank_select_register_q <= op[4:0];
                end
                else if (is_plit)
                begin
                    pc_high_latch_q <= op[6:0];
                end
            end
            else if (apb_wr)
            begin
                case (paddr)
                    `MIE_OFF_ACC:    acc_q <= pwdata[7:0];
                    `MIE_OFF_STATUS: zero_q <= pwdata[`MIE_ST_ZERO];
                    `MIE_OFF_BANK:   bank_select_register_q <= pwdata[4:0];
                    `MIE_OFF_PCHI:   pc_high_latch_q <= pwdata[6:0];
                    default:         acc_q <= acc_q;
                endcase
            end
        end
    end

    // File array write port; store and copy-back come before a software write
    always @(posedge pclk)
    begin
        if (go && is_store)
        begin
            file_mem[mem_idx] <= acc_q;
        end
        else if (go && is_fcopy && op[`MIE_B_DEST])
        begin
            file_mem[mem_idx] <= rd_val;
        end
        else if (apb_wr && paddr == `MIE_OFF_FDATA)
        begin
            file_mem[faddr_q[FILE_AW-1:0]] <= pwdata[7:0];
        end
    end

    // Register map seen by software:
    //   00 exec word (write only, reads zero)
    //   04 accumulator, 08 status (bit 0 zero, bit 1 bad opcode)
    //   0c bank select, 10 pc high latch
    //   14 and 18 the two pointers
    //   1c file index, 20 file data at that index
    // Narrow fields sit in the low bits; upper bits read zero.
    // Unmapped offsets answer with pslverr and read zero.
    // Read mux for the APB answer
    reg [31:0] rd_mux;
    reg        map_hit;
    always @*
    begin
        map_hit = 1'b1;
        case (paddr)
            `MIE_OFF_EXEC:   rd_mux = 32'h0000_0000;
            `MIE_OFF_ACC:    rd_mux = {24'h00_0000, acc_q};
            `MIE_OFF_STATUS: rd_mux = {30'h0000_0000, bad_op_q, zero_q};
            `MIE_OFF_BANK:   rd_mux = {27'h000_0000, bank_select_register_q};
            `MIE_OFF_PCHI:   rd_mux = {25'h000_0000, pc_high_latch_q};
            `MIE_OFF_PTR0:   rd_mux = {16'h0000, ptr0_q};
            `MIE_OFF_PTR1:   rd_mux = {16'h0000, ptr1_q};
            `MIE_OFF_FADDR:  rd_mux = {25'h000_0000, faddr_q};
            `MIE_OFF_FDATA:  rd_mux = {24'h00_0000, file_mem[faddr_q[FILE_AW-1:0]]};
            default:
            begin
                rd_mux  = 32'h0000_0000;
                map_hit = 1'b0;
            end
        endcase
    end

    // APB answer is prepared in the setup cycle so the access phase has no wait state
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~map_hit;                    // Unmapped offset, either direction
            // Data is cleared after the access so a stale word never lingers on the bus
            if (apb_setup && !pwrite)
            begin
                prdata <= rd_mux;
            end
            else if (apb_acc)
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule

// ### design/mie_defs.vh
// Constants for the data-move instruction executor.
// Assumes 14-bit instruction words and an APB slave with 32-bit data.
`ifndef MIE_DEFS_VH
`define MIE_DEFS_VH

// APB register byte offsets
`define MIE_OFF_EXEC      8'h00
`define MIE_OFF_ACC       8'h04
`define MIE_OFF_STATUS    8'h08
`define MIE_OFF_BANK      8'h0c
`define MIE_OFF_PCHI      8'h10
`define MIE_OFF_PTR0      8'h14
`define MIE_OFF_PTR1      8'h18
`define MIE_OFF_FADDR     8'h1c
`define MIE_OFF_FDATA     8'h20

// Status register field positions
`define MIE_ST_ZERO       0
`define MIE_ST_BADOP      1

// Reset values
`define MIE_RST_ACC       8'h00
`define MIE_RST_BANK      5'h00
`define MIE_RST_PCHI      7'h00
`define MIE_RST_PTR       16'h0000

// File addresses that stand for the virtual indirect registers
`define MIE_VIRT0         7'h00
`define MIE_VIRT1         7'h01

// Opcode patterns and masks
`define MIE_MSK_FCOPY     14'h3f00
`define MIE_PAT_FCOPY     14'h0800
`define MIE_MSK_STORE     14'h3f80
`define MIE_PAT_STORE     14'h0080
`define MIE_MSK_ALIT      14'h3f00
`define MIE_PAT_ALIT      14'h3000
`define MIE_MSK_BLIT      14'h3fe0
`define MIE_PAT_BLIT      14'h0020
`define MIE_MSK_PLIT      14'h3f80
`define MIE_PAT_PLIT      14'h3180
`define MIE_MSK_ILOAD     14'h3ff8
`define MIE_PAT_ILOAD     14'h0010
`define MIE_MSK_IOFS      14'h3f80
`define MIE_PAT_IOFS      14'h3f00

// Field positions inside the instruction word
`define MIE_B_DEST        7
`define MIE_B_NSEL        2
`define MIE_B_NSEL_OFS    6

// Pointer step
`define MIE_PTR_ONE       16'h0001

`endif

// ### bench/mie_props.sv
// Assertion checker for the move executor, bound to its ports.
// Assumes one pclk domain and decode words arriving on instr.
`include "mie_defs.vh"
module mie_props_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        instr_valid,
    input wire [13:0] instr,
    input wire [7:0]  acc_q,
    input wire        zero_q,
    input wire [4:0]  bank_select_register_q,
    input wire [6:0]  pc_high_latch_q,
    input wire [15:0] ptr0_q,
    input wire [15:0] ptr1_q,
    input wire        exec_done_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Opcode strobes, gated by valid so stale words never count
    wire blit = instr_valid && ((instr & `MIE_MSK_BLIT) == `MIE_PAT_BLIT);
    wire plit = instr_valid && ((instr & `MIE_MSK_PLIT) == `MIE_PAT_PLIT);
    wire alit = instr_valid && ((instr & `MIE_MSK_ALIT) == `MIE_PAT_ALIT);
    wire stor = instr_valid && ((instr & `MIE_MSK_STORE) == `MIE_PAT_STORE);
    wire fcop = instr_valid && ((instr & `MIE_MSK_FCOPY) == `MIE_PAT_FCOPY);
    wire ild = instr_valid && ((instr & `MIE_MSK_ILOAD) == `MIE_PAT_ILOAD);
    wire ofs = instr_valid && ((instr & `MIE_MSK_IOFS) == `MIE_PAT_IOFS);
    property p_bank; blit |=> bank_select_register_q == $past(instr[4:0]) && $stable(zero_q); endproperty
    a_bank: assert property (p_bank) else $error("bank literal wrong");
    property p_page; plit |=> pc_high_latch_q == $past(instr[6:0]) && $stable(zero_q); endproperty
    a_page: assert property (p_page) else $error("page literal wrong");
    property p_alit; alit |=> acc_q == $past(instr[7:0]) && $stable(zero_q); endproperty
    a_alit: assert property (p_alit) else $error("acc literal wrong");
    property p_stor; stor |=> $stable(acc_q) && $stable(zero_q); endproperty
    a_stor: assert property (p_stor) else $error("store disturbed acc");
    property p_inc; ild && !instr[`MIE_B_NSEL] && !instr[0] |=> ptr0_q == $past(ptr0_q) + 16'h0001; endproperty
    a_inc: assert property (p_inc) else $error("pointer step up wrong");
    property p_dec; ild && instr[`MIE_B_NSEL] && instr[0] |=> ptr1_q == $past(ptr1_q) - 16'h0001; endproperty
    a_dec: assert property (p_dec) else $error("pointer step down wrong");
    property p_ofs; ofs |=> $stable(ptr0_q) && $stable(ptr1_q); endproperty
    a_ofs: assert property (p_ofs) else $error("offset form moved pointer");
    property p_izero; ild |=> zero_q == (acc_q == 8'h00); endproperty
    a_izero: assert property (p_izero) else $error("indirect zero flag wrong");
    property p_fzero; fcop && !instr[`MIE_B_DEST] |=> zero_q == (acc_q == 8'h00); endproperty
    a_fzero: assert property (p_fzero) else $error("copy zero flag wrong");
    property p_done; instr_valid |=> exec_done_q; endproperty
    a_done: assert property (p_done) else $error("move took more than a cycle");
    c_ild: cover property (ild);
    c_ofs: cover property (ofs);
    c_fcop: cover property (fcop);
endmodule
bind mie_move_exec mie_props_chk chk_u (.pclk(pclk), .presetn(presetn), .instr_valid(instr_valid),
    .instr(instr), .acc_q(acc_q), .zero_q(zero_q), .bank_select_register_q(bank_select_register_q),
    .pc_high_latch_q(pc_high_latch_q), .ptr0_q(ptr0_q), .ptr1_q(ptr1_q), .exec_done_q(exec_done_q));

// ### bench/mie_decode_model.sv
// Decode-stage model that hands instruction words to the executor.
// Assumes one pclk domain; one word at a time.
module mie_decode_model (
    input  wire         pclk,
    output logic        instr_valid,
    output logic [13:0] instr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        instr_valid = 1'b0;
        instr = 14'h0000;
    end
    // Word stands one cycle; then the inverse, so a stale word is never mistaken
    task issue(input logic [13:0] w);
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr <= w;
        @(posedge pclk);
        instr_valid <= 1'b0;
        instr <= ~w;
    endtask
endmodule

// ### bench/move_instruction_executor_test.sv
// Self-checking bench for the move executor with a decode-stage model.
// Assumes a zero-wait APB slave and one-cycle instruction execution.
module move_instruction_executor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    logic        err;
    wire  [31:0] prdata;
    wire         pready, pslverr, instr_valid, zero_q, exec_done_q, bad_op_q;
    wire  [13:0] instr;
    wire  [7:0]  acc;
    wire  [4:0]  bank_sel;
    wire  [6:0]  pch;
    wire  [15:0] p0, p1;
    int          failures, n_tests;
    mie_decode_model dec_u (.pclk(pclk), .instr_valid(instr_valid), .instr(instr));
    mie_move_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr(instr), .acc_q(acc), .zero_q(zero_q), .bank_select_register_q(bank_sel),
        .pc_high_latch_q(pch), .ptr0_q(p0), .ptr1_q(p1), .exec_done_q(exec_done_q), .bad_op_q(bad_op_q));
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task stop_test;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One APB transfer; waits on pready as long as needed, only the watchdog ends a dead wait
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task exe(input logic [13:0] w);
        dec_u.issue(w);
        #1;
        chk(exec_done_q, 1);
    endtask
    // Literal loads with the zero flag preset, so a stray clear shows
    task t_lit;
        apb(1, 8'h08, 32'h1);
        exe(14'h003f); chk(bank_sel, 32'h1f);
        exe(14'h31ff); chk(pch, 32'h7f);
        exe(14'h30ff); chk(acc, 32'hff);
        chk(zero_q, 1);
    endtask
    task t_move;
        exe(14'h305a); exe(14'h0086); chk(acc, 32'h5a);
        apb(1, 8'h1c, 32'h6); apb(0, 8'h20, 0); chk(rd, 32'h5a);
        exe(14'h3000); exe(14'h0806); chk(acc, 32'h5a);
        chk(zero_q, 0);
        exe(14'h3000); exe(14'h0085); exe(14'h3077); exe(14'h0885); chk(zero_q, 1);
        chk(acc, 32'h77);
        apb(1, 8'h1c, 32'h5); apb(0, 8'h20, 0); chk(rd, 32'h0);
    endtask
    // Software-issued words, an unknown opcode and an unmapped offset
    task t_sw;
        apb(1, 8'h00, 32'h3042); apb(0, 8'h04, 0); chk(rd, 32'h42);
        apb(1, 8'h00, 32'h3fff);
        #1;
        chk(bad_op_q, 1);
        chk(acc, 32'h42);
        apb(0, 8'h40, 0); chk(err, 1);
        chk(rd, 0);
    endtask
    // All four step modes, wrap at both ends, offset form and virtual store
    task t_ind;
        apb(1, 8'h14, 32'hffff); apb(1, 8'h1c, 0); apb(1, 8'h20, 32'h33);
        exe(14'h0010); chk(p0, 0);
        chk(acc, 32'h33);
        exe(14'h0013); chk(p0, 32'hffff);
        apb(1, 8'h18, 32'h10); apb(1, 8'h1c, 32'hf); apb(1, 8'h20, 0);
        exe(14'h0015); chk(p1, 32'hf);
        chk(zero_q, 1);
        exe(14'h0016); chk(p1, 32'h10);
        exe(14'h3f70); chk(acc, 32'h33);
        chk(p1, 32'h10);
        exe(14'h0081); apb(1, 8'h1c, 32'h10); apb(0, 8'h20, 0); chk(rd, 32'h33);
    endtask
    initial
    begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        presetn = 0; failures = 0; n_tests = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk({acc, bank_sel, pch, p0}, 0);
        t_lit;
        t_sw;
        t_move;
        t_ind;
        stop_test;
    end
    // Whole run is about ten microseconds; this limit is far beyond it
    initial
    begin
        #200000;
        failures++;
        stop_test;
    end
endmodule
